// ### fmc_regs.svh
// timing counts and field positions for the flash mode controller
`ifndef FMC_REGS_SVH
`define FMC_REGS_SVH
`define FMC_CLK_PERIOD_NS      40
`define FMC_ADDR_W             22
`define FMC_DATA_W             8
`define FMC_SECTOR_HI          21
`define FMC_SECTOR_LO          16
`define FMC_ADDRESS_ACCESS_TIME_NS           70
`define FMC_T_RP_NS            500
`define FMC_T_RH_NS            50
`define FMC_T_READY_NS         20000
`define FMC_T_SETUP_NS         40
`define FMC_T_WE_NS            40
`define FMC_CYC_ACC   ((`FMC_ADDRESS_ACCESS_TIME_NS + `FMC_CLK_PERIOD_NS - 1) / `FMC_CLK_PERIOD_NS)
`define FMC_CYC_RP    ((`FMC_T_RP_NS + `FMC_CLK_PERIOD_NS - 1) / `FMC_CLK_PERIOD_NS)
`define FMC_CYC_RH    ((`FMC_T_RH_NS + `FMC_CLK_PERIOD_NS - 1) / `FMC_CLK_PERIOD_NS)
`define FMC_CYC_READY ((`FMC_T_READY_NS + `FMC_CLK_PERIOD_NS - 1) / `FMC_CLK_PERIOD_NS)
`define FMC_CYC_WE    ((`FMC_T_WE_NS + `FMC_CLK_PERIOD_NS - 1) / `FMC_CLK_PERIOD_NS)
`define FMC_CMD_UNLOCK_ADDR    22'h00_0AAA
`define FMC_CMD_PROG_DATA      8'hA0
`endif

// ### fmc_pkg.sv
// types of the flash mode controller
package fmc_pkg;
	typedef enum logic [2:0] {
		FMC_IDLE   = 3'b000,
		FMC_RDSET  = 3'b001,
		FMC_RDWAIT = 3'b011,
		FMC_WR1    = 3'b010,
		FMC_WR2    = 3'b110,
		FMC_RSTLO  = 3'b111,
		FMC_RSTHI  = 3'b101,
		FMC_GAP    = 3'b100
	} fmc_state_t;
endpackage

// ### fmc_host.sv
// host-side controller for a parallel nor flash: read, accelerated program, reset
`timescale 1ns/1ps
`default_nettype none
`include "fmc_regs.svh"

// Functional notes
// [RQ1] device unlocks bypass while accelerate pin high
// [RQ2] host programs with two-cycle bypass sequence
// [RQ3] dropping high voltage returns normal mode
// [RQ4] high voltage only while programming, never floating; code drives it from accelEnable in every state
// [RQ5] standby tri-states data regardless of gate
// [RQ6] chip-select and reset high give standby
// [RQ7] read valid after chip-select access time
// [RQ8] deselect keeps program or erase running
// [RQ9] stable address enters sleep after access+30ns
// [RQ10] sleep entry ignores control inputs
// [RQ11] sleep keeps data latched, new data normally
// [RQ12] reset pulse aborts, tri-states, ignores access
// [RQ13] reset returns device to array read
// [RQ14] host restarts operation interrupted by reset; code only raises retryNeeded for the user to restart
// [RQ15] reset during program busy until ready time
// [RQ16] idle reset finishes within shorter time
// [RQ17] host waits recovery time before reading
// [RQ18] gate high disables data outputs
// [RQ19] six upper address bits pick sector
// [RQ20] bypass program takes two write cycles
// [RQ21] power-up starts in array read
module fmc_host
	import fmc_pkg::*;
#(
	parameter int RP_CYC    = `FMC_CYC_RP,
	parameter int READY_CYC = `FMC_CYC_READY
)(
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	input  wire logic                    clkEn,
	// user command port
	input  wire logic                    reqRead,
	input  wire logic                    reqProg,
	input  wire logic                    reqReset,
	input  wire logic                    accelEnable,
	input  wire logic [`FMC_ADDR_W-1:0]  reqAddr,
	input  wire logic [`FMC_DATA_W-1:0]  reqData,
	output logic                         reqBusy,
	output logic                         rdValid,
	output logic [`FMC_DATA_W-1:0]       rdData,
	output logic [5:0]                   sectorIndex,
	output logic                         retryNeeded,
	// flash pins
	output logic [`FMC_ADDR_W-1:0]       flashAddr,
	input  wire logic [`FMC_DATA_W-1:0]  flashDataIn,
	output logic [`FMC_DATA_W-1:0]       flashDataOut,
	output logic                         flashDataOe,
	output logic                         chipSelN,
	output logic                         outGateN,
	output logic                         writeStrobeN,
	output logic                         flashResetN,
	output logic                         protectAccelHigh,
	input  wire logic                    readyBusyN
);
	// refuse counts that the 16-bit counter or the recovery wait cannot serve
	if (RP_CYC < 1 || RP_CYC > 65535 || READY_CYC <= `FMC_CYC_RH || READY_CYC > 65535)
	begin
		$error("fmc_host: timing counts out of range");
	end

	fmc_state_t                state_q, state_d;
	logic [15:0]               cnt_q;
	logic [`FMC_DATA_W-1:0]    sync1_q, sync2_q;
	logic                      rb1_q, rb2_q;
	logic                      progActive_q;
	logic                      cntDone;
	logic [15:0]               cntLoad;
	logic                      loadCnt;
	logic [15:0]               cntNext;
	logic                      writeNext;
	logic [15:0]               rhMark;

	assign cntDone = (cnt_q == 16'h0000);
	// next count, write-cycle selection and the count left once recovery has passed
	assign cntNext   = loadCnt ? cntLoad : (cntDone ? cnt_q : cnt_q - 16'h0001);
	assign writeNext = (state_d == FMC_WR1 || state_d == FMC_WR2);
	assign rhMark    = 16'(READY_CYC - `FMC_CYC_RH);

	// pin synchronisers for data and ready/busy
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			rb1_q   <= 1'b1;
			rb2_q   <= 1'b1;
		end
		else if (clkEn)
		begin
			sync1_q <= flashDataIn;
			sync2_q <= sync1_q;
			rb1_q   <= readyBusyN;
			rb2_q   <= rb1_q;
		end

	// next state: reset first, then program, then read
	always_comb
	begin
		state_d = state_q;
		loadCnt = 1'b0;
		cntLoad = 16'h0000;
		case (state_q)
			FMC_IDLE:
				if (reqReset)
				begin
					state_d = FMC_RSTLO;
					loadCnt = 1'b1;
					cntLoad = 16'(RP_CYC);
				end
				else if (reqProg)
				begin
					state_d = FMC_WR1; // RQ2
					loadCnt = 1'b1;
					cntLoad = 16'(`FMC_CYC_WE + 1); // one setup cycle before the strobe
				end
				else if (reqRead)
				begin
					state_d = FMC_RDSET;
					loadCnt = 1'b1;
					cntLoad = 16'(`FMC_CYC_ACC + 1); // RQ7
				end
			FMC_RDSET:
				if (cntDone)
				begin
					state_d = FMC_RDWAIT;
					loadCnt = 1'b1;
					cntLoad = 16'd2;
				end
			FMC_RDWAIT:
				if (cntDone)
					state_d = FMC_GAP;
			FMC_WR1:
				if (cntDone)
				begin
					state_d = FMC_WR2; // RQ20
					loadCnt = 1'b1;
					cntLoad = 16'(`FMC_CYC_WE + 1); // one setup cycle before the strobe
				end
			FMC_WR2:
				if (cntDone)
					state_d = FMC_GAP;
			FMC_RSTLO:
				if (cntDone)
				begin
					state_d = FMC_RSTHI;
					loadCnt = 1'b1;
					cntLoad = 16'(READY_CYC); // RQ15 RQ16 RQ17
				end
			FMC_RSTHI:
				if (cntDone || (cnt_q <= rhMark && rb2_q)) // RQ17
					state_d = FMC_GAP;
			FMC_GAP:
				state_d = FMC_IDLE;
			default:
				state_d = FMC_IDLE;
		endcase
	end

	// state and counter
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			state_q <= FMC_IDLE; // RQ21
			cnt_q   <= 16'h0000;
		end
		else if (clkEn)
		begin
			state_q <= state_d;
			cnt_q   <= cntNext;
		end

	// pin and user outputs, all registered
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			flashAddr        <= '0;
			flashDataOut     <= '0;
			flashDataOe      <= 1'b0;
			chipSelN         <= 1'b1; // RQ6
			outGateN         <= 1'b1; // RQ18
			writeStrobeN     <= 1'b1;
			flashResetN      <= 1'b1;
			protectAccelHigh <= 1'b0; // RQ4
			reqBusy          <= 1'b0;
			rdValid          <= 1'b0;
			rdData           <= '0;
			sectorIndex      <= 6'h00;
			retryNeeded      <= 1'b0;
			progActive_q     <= 1'b0;
		end
		else if (clkEn)
		begin
			rdValid          <= 1'b0;
			reqBusy          <= (state_d != FMC_IDLE);
			protectAccelHigh <= accelEnable; // RQ1 RQ3 RQ4
			// address held stable between accesses so the device may sleep
			if (state_q == FMC_IDLE && state_d != FMC_IDLE && state_d != FMC_RSTLO)
			begin
				flashAddr   <= (state_d == FMC_WR1) ? `FMC_CMD_UNLOCK_ADDR : reqAddr;
				sectorIndex <= reqAddr[`FMC_SECTOR_HI:`FMC_SECTOR_LO]; // RQ19
				flashDataOut <= (state_d == FMC_WR1) ? `FMC_CMD_PROG_DATA : reqData;
			end
			if (state_q == FMC_WR1 && state_d == FMC_WR2)
			begin
				flashAddr    <= reqAddr;
				flashDataOut <= reqData;
			end
			chipSelN     <= !(state_d == FMC_RDSET || state_d == FMC_RDWAIT ||
				state_d == FMC_WR1 || state_d == FMC_WR2); // RQ8
			outGateN     <= !(state_d == FMC_RDSET || state_d == FMC_RDWAIT);
			// strobe low only inside the cycle, so address, data and select hold past its rise
			writeStrobeN <= !(writeNext && cntNext != 16'h0000 && cntNext <= 16'(`FMC_CYC_WE)); // RQ20
			flashDataOe  <= (state_d == FMC_WR1 || state_d == FMC_WR2);
			flashResetN  <= (state_d != FMC_RSTLO); // RQ12 RQ13
			if (state_q == FMC_RDWAIT && cntDone)
			begin
				rdValid <= 1'b1;
				rdData  <= sync2_q;
			end
			if (state_q == FMC_WR2 && cntDone)
				progActive_q <= 1'b1;
			else if (rb2_q && state_q == FMC_IDLE)
				progActive_q <= 1'b0;
			if (state_q == FMC_RSTLO && cntDone && (progActive_q || !rb2_q))
				retryNeeded <= 1'b1; // RQ14
			else if (reqProg && state_q == FMC_IDLE)
				retryNeeded <= 1'b0;
		end
endmodule
`default_nettype wire

// ### fmc_host_properties.sv
// checker of the flash controller pins
`timescale 1ns/1ps
`default_nettype none
`include "fmc_regs.svh"
module fmc_host_properties(
	// clock and user side
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic accelEnable,
	input wire logic reqBusy,
	input wire logic rdValid,
	// flash pins
	input wire logic flashDataOe,
	input wire logic chipSelN,
	input wire logic outGateN,
	input wire logic writeStrobeN,
	input wire logic flashResetN,
	input wire logic protectAccelHigh,
	input wire logic [`FMC_ADDR_W-1:0] flashAddr,
	input wire logic [`FMC_DATA_W-1:0] flashDataOut
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// relations among the flash pins and between them and the user side
	property p_oe; flashDataOe |-> outGateN; endproperty
	a_oe: assert property (p_oe) else $error("data driven with gate low");
	property p_we; !writeStrobeN |-> !chipSelN && outGateN; endproperty
	a_we: assert property (p_we) else $error("bad write cycle");
	property p_rq; !flashResetN |-> chipSelN && writeStrobeN; endproperty
	a_rq: assert property (p_rq) else $error("access in reset");
	property p_rb; !flashResetN |-> reqBusy; endproperty
	a_rb: assert property (p_rb) else $error("idle in reset");
	property p_rw; $fell(flashResetN) |=> !flashResetN[*8]; endproperty
	a_rw: assert property (p_rw) else $error("reset pulse short");
	property p_ac; $past(clkEn) |-> protectAccelHigh == $past(accelEnable); endproperty
	a_ac: assert property (p_ac) else $error("accel pin lag");
	property p_vp; rdValid |=> !rdValid; endproperty
	a_vp: assert property (p_vp) else $error("valid too long");
	property p_rd; $fell(outGateN) |-> ##[1:12] rdValid; endproperty
	a_rd: assert property (p_rd) else $error("read late");
	property p_wh;
		$rose(writeStrobeN) |-> $stable(flashAddr) && $stable(flashDataOut) && !chipSelN;
	endproperty
	a_wh: assert property (p_wh) else $error("write hold broken");
endmodule
bind fmc_host fmc_host_properties u_chk(.*);
`default_nettype wire

// ### fmc_flash_model.sv
// behavioural flash device answering the controller
`timescale 1ns/1ps
`default_nettype none
`include "fmc_regs.svh"
module fmc_flash_model(
	// controller pins
	input wire logic        clk,
	input wire logic [21:0] a,
	input wire logic [7:0]  d,
	input wire logic        csN,
	input wire logic        oeN,
	input wire logic        weN,
	input wire logic        rstN,
	input wire logic        acc,
	// answers
	output logic [7:0]      q,
	output logic            rdyN
);
	logic [7:0] mem [int];
	logic [7:0] hold = 8'h00;
	int         busy = 0;
	bit         arm = 0;
	logic [21:0] aLast = 22'h00_0000;
	logic [7:0] sleepData = 8'h00;
	int         still = 0;
	localparam int SLEEP_CYC =
		(`FMC_ADDRESS_ACCESS_TIME_NS + 30 + `FMC_CLK_PERIOD_NS - 1) / `FMC_CLK_PERIOD_NS;
	// drive when selected and gated, else a pattern changing each cycle; asleep, the latch
	always @*
		if (!csN && !oeN && rstN)
			q = (still >= SLEEP_CYC) ? sleepData : (mem.exists(a) ? mem[a] : a[7:0]);
		else
			q = ~hold;
	assign rdyN = busy == 0;
	// sleep count ignores the control pins; busy count; reset returns to array read
	always @(posedge clk)
	begin
		hold <= q;
		aLast <= a;
		still <= (a != aLast || busy > 0) ? 0 :
			(still < SLEEP_CYC) ? still + 1 : still;
		if (still < SLEEP_CYC) sleepData <= mem.exists(a) ? mem[a] : a[7:0];
		if (!rstN)
		begin
			arm = 0;
			if (busy > 0) busy = 9;
		end
		else if (busy > 0) busy--;
	end
	// two-cycle bypass program only while accelerate pin is high
	always @(posedge weN)
		if (!csN && rstN && acc)
		begin
			if (arm) mem[a] = d;
			if (arm) busy = 30;
			arm = !arm && d == 8'hA0;
		end
endmodule
`default_nettype wire

// ### fmc_host_tb.sv
// self-checking bench of the flash controller
`timescale 1ns/1ps
`default_nettype none
module fmc_host_tb;
	logic ref_clk = 0, nrst = 0, clkEn = 1, accelEnable = 0;
	logic reqRead = 0, reqProg = 0, reqReset = 0, reqBusy, rdValid, retryNeeded;
	logic [21:0] reqAddr = 0, flashAddr;
	logic [7:0] reqData = 0, rdData, flashDataIn, flashDataOut;
	logic [5:0] sectorIndex;
	logic flashDataOe, chipSelN, outGateN, writeStrobeN, flashResetN, protectAccelHigh, readyBusyN;
	logic [7:0] refMem [int];
	int n_fail = 0, tests_run = 0, i = 0;
	always #20 ref_clk = ~ref_clk;
	fmc_host dut(.*);
	fmc_flash_model dev(.clk(ref_clk), .a(flashAddr), .d(flashDataOut), .csN(chipSelN),
		.oeN(outGateN), .weN(writeStrobeN), .rstN(flashResetN), .acc(protectAccelHigh),
		.q(flashDataIn), .rdyN(readyBusyN));
	task automatic chk(input logic [7:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic print_verdict;
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one operation: 0 read, 1 program, 2 reset, under one shared wait budget
	task automatic op(input int k, input logic [21:0] a, input logic [7:0] d);
		for (; i < 3000 && reqBusy; i++) @(posedge ref_clk);
		reqRead <= k == 0;
		reqProg <= k == 1;
		reqReset <= k == 2;
		reqAddr <= a;
		reqData <= d;
		for (; i < 3000 && !reqBusy; i++) @(posedge ref_clk);
		{reqRead, reqProg, reqReset} <= 3'h0;
		for (; i < 3000 && (k ? reqBusy : !rdValid); i++) @(posedge ref_clk);
		if (i >= 3000)
		begin
			n_fail++;
			print_verdict;
		end
		if (k == 0) chk(rdData, refMem.exists(a) ? refMem[a] : a[7:0]);
		if (k < 2) chk(8'(sectorIndex), 8'(a[21:16]));
	endtask
	initial
	begin
		logic [21:0] a;
		int n;
		a = 22'($urandom(32'h0000_5331));
		repeat (2) @(posedge ref_clk);
		nrst <= 1;
		for (n = 0; n < 6; n++) op(0, n ? 22'($urandom) : 22'h3F_FFFF, 8'h00);
		op(2, 22'h0, 8'h00);
		chk(8'(retryNeeded), 8'h00);
		accelEnable <= 1;
		op(1, a, 8'h3C);
		refMem[a] = 8'h3C;
		op(0, a, 8'h00);
		chk(8'(protectAccelHigh), 8'h01);
		accelEnable <= 0;
		op(1, a ^ 22'h1, 8'h77);
		op(0, a ^ 22'h1, 8'h00);
		accelEnable <= 1;
		op(1, a ^ 22'h2, 8'h5A);
		refMem[a ^ 22'h2] = 8'h5A;
		op(2, 22'h0, 8'h00);
		chk(8'(retryNeeded), 8'h01);
		op(0, a ^ 22'h2, 8'h00);
		op(1, a ^ 22'h2, 8'h5A);
		chk(8'(retryNeeded), 8'h00);
		op(0, a ^ 22'h2, 8'h00);
		print_verdict;
	end
endmodule
`default_nettype wire
